// ===== hw/smbus_cfg.svh
`ifndef SMBUS_CFG_SVH
`define SMBUS_CFG_SVH

// Seven-bit target address; on the wire the write-address byte reads 12h
`define SMB_ADDR7       7'h09

// Identification commands
`define SMB_CMD_MAKER   8'hfe
`define SMB_CMD_PART    8'hff

// Bits in one byte
`define SMB_BYTE_BITS   4'h8
`define SMB_CNT_ZERO    4'h0
`define SMB_CNT_ONE     4'h1
`define SMB_CNT_STEP    4'h1

// Reset values
`define SMB_BYTE_RST    8'h00
`define SMB_WORD_RST    16'h0000

`endif

// ===== hw/smbus_pkg.sv
package smbus_pkg;

  // Gray codes along idle, address, command, write, read
  typedef enum logic [3:0] {
    st_idle     = 4'h0,
    st_addr     = 4'h1,
    st_addr_ack = 4'h3,
    st_cmd      = 4'h2,
    st_cmd_ack  = 4'h6,
    st_wr       = 4'h7,
    st_wr_ack   = 4'h5,
    st_rd       = 4'h4,
    st_rd_ack   = 4'hc,
    st_skip     = 4'hd
  } state_e;

  typedef struct packed {
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
  } sense_s;

  typedef struct packed {
    state_e      state;
    logic [3:0]  bit_cnt;
    logic [7:0]  shift;
    logic [7:0]  cmd;
    logic        cmd_ok;
    logic        is_read;
    logic        high_byte;
    logic [7:0]  low_byte;
    logic [15:0] tx;
    logic        sda_oe;
    logic        sda_out;
    logic        wr_valid;
    logic [7:0]  wr_cmd;
    logic [15:0] wr_data;
  } port_s;

endpackage : smbus_pkg

// ===== hw/smbus_line_sense.sv
`timescale 1ns/10ps
`include "smbus_cfg.svh"

module smbus_line_sense (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic reset_n,
  // Bus lines
  input  wire logic scl_in,
  input  wire logic sda_in,
  // Conditioned levels and events
  output logic      scl,
  output logic      sda,
  output logic      scl_rise,
  output logic      scl_fall,
  output logic      start,
  output logic      stop
);

  smbus_pkg::sense_s s_q;
  smbus_pkg::sense_s s_d;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_d          = s_q;
    s_d.scl      = scl_in;
    s_d.sda      = sda_in;
    s_d.scl_rise = ~s_q.scl & scl_in;
    s_d.scl_fall = s_q.scl & ~scl_in;
    s_d.start    = s_q.scl & scl_in & s_q.sda & ~sda_in;
    s_d.stop     = s_q.scl & scl_in & ~s_q.sda & sda_in;
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      s_q <= '{scl: 1'b1, sda: 1'b1, default: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign scl      = s_q.scl;
  assign sda      = s_q.sda;
  assign scl_rise = s_q.scl_rise;
  assign scl_fall = s_q.scl_fall;
  assign start    = s_q.start;
  assign stop     = s_q.stop;

endmodule : smbus_line_sense

// ===== hw/smbus_word_slave_port.sv
//
// Function
// - Answer only to the fixed target address, ignoring every other address.
// - Never act as master: no start of its own and no drive on the clock line.
// - All commands travel as write-word or read-word, one 16-bit value per 8-bit command.
// - A falling data line while the clock is high is a start, seen at any point.
// - A rising data line while the clock is high is a stop, after which the bus is free.
// - The data line changes only while the clock is low, save for start and stop.
// - Bytes are eight bits, MSB first, sampled on the rising clock edge.
// - Each byte takes nine clocks, the ninth carrying the receiver's acknowledge.
// - Acknowledge is a low data line; address, command and written bytes are acknowledged.
// - All bytes of a transaction lie between its start and its stop.
// - A repeated start after the command keeps the command for the read phase.
// - Reads return low then high byte; master acknowledges low, not high, then stops.
// - Two read-only 16-bit identification registers sit at commands FFh and FEh.
// - The maker identification always returns the same fixed code.
//
`timescale 1ns/10ps
`include "smbus_cfg.svh"

module smbus_word_slave_port #(
  // Arbitrary identification values
  parameter logic [15:0] MAKER_CODE = 16'h00a5,
  parameter logic [15:0] PART_CODE  = 16'h1234
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  // Bus clock, input only
  input  wire logic        scl_in,
  // Bus data, open drain
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  // Register write side
  output logic             wr_valid,
  output logic [7:0]       wr_cmd,
  output logic [15:0]      wr_data,
  // Register read side
  output logic [7:0]       rd_cmd,
  input  wire logic [15:0] rd_data
);

  ////////////////////////////////////////////////////////////////////////////
  // Line conditioning

  logic scl_lvl;
  logic sda_lvl;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;

  smbus_line_sense u_sense (
    .sys_clk  (sys_clk),
    .reset_n  (reset_n),
    .scl_in   (scl_in),
    .sda_in   (sda_in),
    .scl      (scl_lvl),
    .sda      (sda_lvl),
    .scl_rise (scl_rise),
    .scl_fall (scl_fall),
    .start    (start_ev),
    .stop     (stop_ev)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read word selection

  function automatic logic [15:0] read_word(
    input logic [7:0]  cmd,
    input logic [15:0] ext
  );
    logic [15:0] w;
    case (cmd)
      `SMB_CMD_MAKER: w = MAKER_CODE;
      `SMB_CMD_PART:  w = PART_CODE;
      default:        w = ext;
    endcase
    return w;
  endfunction : read_word

  ////////////////////////////////////////////////////////////////////////////
  // State

  smbus_pkg::port_s p_q;
  smbus_pkg::port_s p_d;

  logic [15:0] word;
  logic        byte_done;

  assign word      = read_word(p_q.cmd, rd_data);
  assign byte_done = (p_q.bit_cnt == `SMB_BYTE_BITS);

  always_comb begin
    p_d          = p_q;
    p_d.wr_valid = 1'b0;
    p_d.sda_out  = 1'b0;
    if (start_ev) begin
      // Start or repeated start; command kept
      p_d.state     = smbus_pkg::st_addr;
      p_d.bit_cnt   = `SMB_CNT_ZERO;
      p_d.sda_oe    = 1'b0;
      p_d.high_byte = 1'b0;
    end else if (stop_ev) begin
      p_d.state  = smbus_pkg::st_idle;
      p_d.sda_oe = 1'b0;
      p_d.cmd_ok = 1'b0;
    end else begin
      case (p_q.state)
        smbus_pkg::st_addr,
        smbus_pkg::st_cmd,
        smbus_pkg::st_wr: begin
          if (scl_rise && !byte_done) begin
            p_d.shift   = {p_q.shift[6:0], sda_lvl};
            p_d.bit_cnt = p_q.bit_cnt + `SMB_CNT_STEP;
          end
          if (scl_fall && byte_done) begin
            p_d.bit_cnt = `SMB_CNT_ZERO;
            case (p_q.state)
              smbus_pkg::st_addr: begin
                if (p_q.shift[7:1] == `SMB_ADDR7 && (!p_q.shift[0] || p_q.cmd_ok)) begin
                  p_d.sda_oe  = 1'b1;
                  p_d.is_read = p_q.shift[0];
                  p_d.state   = smbus_pkg::st_addr_ack;
                end else begin
                  p_d.state = smbus_pkg::st_skip;
                end
              end
              smbus_pkg::st_cmd: begin
                p_d.cmd    = p_q.shift;
                p_d.cmd_ok = 1'b1;
                p_d.sda_oe = 1'b1;
                p_d.state  = smbus_pkg::st_cmd_ack;
              end
              default: begin
                p_d.sda_oe = 1'b1;
                p_d.state  = smbus_pkg::st_wr_ack;
                if (p_q.high_byte) begin
                  p_d.wr_valid = 1'b1;
                  p_d.wr_cmd   = p_q.cmd;
                  p_d.wr_data  = {p_q.shift, p_q.low_byte};
                end else begin
                  p_d.low_byte = p_q.shift;
                end
              end
            endcase
          end
        end
        smbus_pkg::st_addr_ack: begin
          if (scl_fall) begin
            p_d.sda_oe  = 1'b0;
            p_d.bit_cnt = `SMB_CNT_ZERO;
            if (p_q.is_read) begin
              // Low byte first, MSB first
              p_d.tx      = {word[7:0], word[15:8]};
              p_d.sda_oe  = ~word[7];
              p_d.bit_cnt = `SMB_CNT_ONE;
              p_d.state   = smbus_pkg::st_rd;
            end else begin
              p_d.state = smbus_pkg::st_cmd;
            end
          end
        end
        smbus_pkg::st_cmd_ack: begin
          if (scl_fall) begin
            p_d.sda_oe    = 1'b0;
            p_d.high_byte = 1'b0;
            p_d.state     = smbus_pkg::st_wr;
          end
        end
        smbus_pkg::st_wr_ack: begin
          if (scl_fall) begin
            p_d.sda_oe = 1'b0;
            if (p_q.high_byte) begin
              p_d.state = smbus_pkg::st_skip;
            end else begin
              p_d.high_byte = 1'b1;
              p_d.state     = smbus_pkg::st_wr;
            end
          end
        end
        smbus_pkg::st_rd: begin
          if (scl_fall) begin
            p_d.tx = {p_q.tx[14:0], 1'b0};
            if (byte_done) begin
              p_d.sda_oe = 1'b0;
              p_d.state  = smbus_pkg::st_rd_ack;
            end else begin
              p_d.sda_oe  = ~p_q.tx[14];
              p_d.bit_cnt = p_q.bit_cnt + `SMB_CNT_STEP;
            end
          end
        end
        smbus_pkg::st_rd_ack: begin
          if (scl_rise) begin
            if (sda_lvl || p_q.high_byte) begin
              p_d.state = smbus_pkg::st_skip;
            end else begin
              p_d.high_byte = 1'b1;
            end
          end
          if (scl_fall) begin
            p_d.sda_oe  = ~p_q.tx[15];
            p_d.bit_cnt = `SMB_CNT_ONE;
            p_d.state   = smbus_pkg::st_rd;
          end
        end
        smbus_pkg::st_skip: begin
          p_d.sda_oe = 1'b0;
        end
        default: begin
          p_d.sda_oe = 1'b0;
          p_d.state  = smbus_pkg::st_idle;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      p_q <= '{
        state:     smbus_pkg::st_idle,
        bit_cnt:   `SMB_CNT_ZERO,
        shift:     `SMB_BYTE_RST,
        cmd:       `SMB_BYTE_RST,
        cmd_ok:    1'b0,
        is_read:   1'b0,
        high_byte: 1'b0,
        low_byte:  `SMB_BYTE_RST,
        tx:        `SMB_WORD_RST,
        sda_oe:    1'b0,
        sda_out:   1'b0,
        wr_valid:  1'b0,
        wr_cmd:    `SMB_BYTE_RST,
        wr_data:   `SMB_WORD_RST
      };
    end else begin
      p_q <= p_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs; no clock drive exists at all
  assign sda_out  = p_q.sda_out;
  assign sda_oe   = p_q.sda_oe;
  assign wr_valid = p_q.wr_valid;
  assign wr_cmd   = p_q.wr_cmd;
  assign wr_data  = p_q.wr_data;
  assign rd_cmd   = p_q.cmd;

endmodule : smbus_word_slave_port

// ===== sim/smbus_port_asserts.sv
`timescale 1ns/10ps

module smbus_port_asserts (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        reset_n,
  // Bus
  input wire logic        scl_in,
  input wire logic        sda_in,
  input wire logic        sda_out,
  input wire logic        sda_oe,
  // Register side
  input wire logic        wr_valid,
  input wire logic [7:0]  wr_cmd,
  input wire logic [15:0] wr_data,
  input wire logic [7:0]  rd_cmd,
  input wire logic [15:0] rd_data
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  sda_low_only_a: assert property (sda_out == 1'b0) else $error("sda_out not low");
  edge_safe_a: assert property ($changed(sda_oe) |-> !scl_in) else $error("sda moved with scl high");
  wr_pulse_a: assert property (wr_valid |=> !wr_valid) else $error("wr_valid too long");
  wr_ack_a: assert property (wr_valid |-> $rose(sda_oe)) else $error("wr_valid without ack");
  wr_hold_a: assert property (!wr_valid |-> $stable(wr_data) && $stable(wr_cmd))
    else $error("write outputs moved");
  wr_cmd_match_a: assert property (wr_valid |-> wr_cmd == rd_cmd) else $error("write command mismatch");
  drive_span_a: assert property ($rose(sda_oe) |-> ##[1:80] !sda_oe) else $error("sda held too long");
  reset_quiet_a: assert property (disable iff (1'b0) !reset_n |=> !sda_oe && !wr_valid && rd_cmd == 8'h00)
    else $error("reset values wrong");
endmodule : smbus_port_asserts

// ===== sim/smbus_host_model.sv
`timescale 1ns/10ps

module smbus_host_model (
  // Clock
  input wire logic sys_clk,
  // Bus
  input wire logic sda,
  output logic     scl,
  output logic     sda_pull
);
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic wait_n(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : wait_n

  // Start or repeated start
  task automatic start;
    sda_pull = 1'b0;
    wait_n(4);
    scl = 1'b1;
    wait_n(4);
    sda_pull = 1'b1;
    wait_n(4);
    scl = 1'b0;
    wait_n(1);
  endtask : start

  task automatic stop;
    sda_pull = 1'b1;
    wait_n(4);
    scl = 1'b1;
    wait_n(4);
    sda_pull = 1'b0;
    wait_n(4);
  endtask : stop

  // Data set while clock low, sampled on high
  task automatic clk_bit(input logic b, output logic r);
    sda_pull = !b;
    wait_n(4);
    scl = 1'b1;
    wait_n(2);
    r = sda;
    wait_n(2);
    scl = 1'b0;
    wait_n(1);
  endtask : clk_bit

  // Eight bits MSB first, then the ninth
  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) clk_bit(d[i], q[i]);
    clk_bit(a, ack);
  endtask : xfer
endmodule : smbus_host_model

// ===== sim/testbench.sv
`timescale 1ns/10ps

module testbench;
  logic        sys_clk;
  logic        reset_n;
  logic        scl;
  logic        pull;
  logic        sda_oe;
  logic        sda_out;
  logic        wr_valid;
  logic        ack;
  logic [7:0]  wr_cmd;
  logic [7:0]  rd_cmd;
  logic [7:0]  q;
  logic [15:0] wr_data;
  logic [15:0] rd_data;
  logic [15:0] r;
  int          err_total;
  int          tests_run;
  int          wr_seen;
  logic [7:0]  cmds [3] = '{8'hfe, 8'hff, 8'h3c};
  logic [15:0] exps [3] = '{16'h00a5, 16'h1234, 16'h5a0f};
  logic [7:0]  bad [3] = '{8'h24, 8'h13, 8'h10};
  wire         sda = ~(sda_oe | pull);

  smbus_word_slave_port #(.MAKER_CODE(16'h00a5), .PART_CODE(16'h1234))
    DUT (.sys_clk(sys_clk), .reset_n(reset_n), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .wr_valid(wr_valid), .wr_cmd(wr_cmd), .wr_data(wr_data),
    .rd_cmd(rd_cmd), .rd_data(rd_data));
  smbus_host_model M (.sys_clk(sys_clk), .sda(sda), .scl(scl), .sda_pull(pull));

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) if (wr_valid === 1'b1) wr_seen++;

  ////////////////////////////////////////
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic word(input logic rd, input logic [7:0] cmd, input logic [15:0] d, output logic [15:0] v);
    M.start();
    M.xfer(8'h12, 1'b1, q, ack);
    check("addr ack", 16'(ack), 16'h0);
    M.xfer(cmd, 1'b1, q, ack);
    check("cmd ack", 16'(ack), 16'h0);
    if (rd) begin
      M.start();
      M.xfer(8'h13, 1'b1, q, ack);
      check("rd addr ack", 16'(ack), 16'h0);
      M.xfer(8'hff, 1'b0, v[7:0], ack);
      M.xfer(8'hff, 1'b1, v[15:8], ack);
    end else begin
      M.xfer(d[7:0], 1'b1, q, ack);
      check("lo ack", 16'(ack), 16'h0);
      M.xfer(d[15:8], 1'b1, q, ack);
      check("hi ack", 16'(ack), 16'h0);
    end
    M.stop();
  endtask : word

  task automatic conclude;
    if (err_total == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : conclude

  ////////////////////////////////////////
  initial begin
    #200000;
    err_total++;
    conclude();
  end

  initial begin
    reset_n = 1'b0;
    rd_data = 16'h5a0f;
    repeat (12) @(negedge sys_clk);
    reset_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    check("oe reset", 16'(sda_oe), 16'h0);
    check("rd_cmd reset", 16'(rd_cmd), 16'h0);
    word(1'b0, 8'h3c, 16'hbeef, r);
    check("wr_data", wr_data, 16'hbeef);
    check("wr_cmd", 16'(wr_cmd), 16'h3c);
    check("wr count", 16'(wr_seen), 16'h1);
    for (int i = 0; i < 3; i++) begin
      word(1'b1, cmds[i], 16'h0, r);
      check("rd word", r, exps[i]);
    end
    check("rd_cmd kept", 16'(rd_cmd), 16'h3c);
    for (int i = 0; i < 3; i++) begin
      M.start();
      M.xfer(bad[i], 1'b1, q, ack);
      check("refused addr", 16'(ack), 16'h1);
      M.stop();
    end
    M.start();
    M.xfer(8'h12, 1'b1, q, ack);
    M.xfer(8'h44, 1'b1, q, ack);
    M.xfer(8'h77, 1'b1, q, ack);
    check("odd byte ack", 16'(ack), 16'h0);
    M.stop();
    check("odd no write", 16'(wr_seen), 16'h1);
    check("odd data kept", wr_data, 16'hbeef);
    word(1'b1, 8'hfe, 16'h0, r);
    check("maker again", r, 16'h00a5);
    M.start();
    M.xfer(8'h12, 1'b1, q, ack);
    M.xfer(8'hfe, 1'b1, q, ack);
    M.start();
    M.xfer(8'h13, 1'b1, q, ack);
    M.xfer(8'hff, 1'b1, q, ack);
    check("nack low byte", 16'(q), 16'h00a5);
    M.xfer(8'hff, 1'b1, q, ack);
    check("released after nack", 16'(q), 16'h00ff);
    M.stop();
    conclude();
  end
endmodule : testbench

bind smbus_word_slave_port smbus_port_asserts chk (.sys_clk(sys_clk), .reset_n(reset_n), .scl_in(scl_in),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .wr_valid(wr_valid), .wr_cmd(wr_cmd),
  .wr_data(wr_data), .rd_cmd(rd_cmd), .rd_data(rd_data));
